// ===== rtl/dram_ctrl_pkg.sv
// Purpose: shared constants and types for the 64k x 1 dram controller
// Assumes: 20 MHz system clock; memory pins sampled as synchronous
// Notes:   times are kept in their own units, cycle counts derived
package dram_ctrl_pkg;

	localparam int CLK_PERIOD_NS      = 50;
	localparam int ROW_BITS           = 8;
	localparam int COL_BITS           = 8;
	localparam int ADDR_BITS          = ROW_BITS + COL_BITS;
	localparam int CNT_BITS           = 8;
	localparam int TIMER_BITS         = 16;

	// power-up and refresh budget
	localparam int INIT_PAUSE_US      = 200;
	localparam int INIT_RAS_CYCLES    = 8;
	localparam int INIT_REFRESH_REQUEST_N_CYCLES   = 8;
	localparam int REFRESH_INTERVAL_MS = 2;
	localparam int REFRESH_ROWS       = 128;
	localparam int REFRESH_SLOT_NS    =
		REFRESH_INTERVAL_MS * 1000000 / REFRESH_ROWS;

	// slower grade, then faster grade, in ns
	localparam int RC_NS_SLOW   = 330;
	localparam int RC_NS_FAST   = 270;
	localparam int RAC_NS_SLOW  = 200;
	localparam int RAC_NS_FAST  = 150;
	localparam int CAC_NS_SLOW  = 135;
	localparam int CAC_NS_FAST  = 100;
	localparam int RASW_NS_SLOW = 200;
	localparam int RASW_NS_FAST = 150;
	localparam int CASW_NS_SLOW = 135;
	localparam int CASW_NS_FAST = 100;
	localparam int RP_NS_SLOW   = 120;
	localparam int RP_NS_FAST   = 100;
	localparam int RAH_NS_SLOW  = 20;
	localparam int RAH_NS_FAST  = 15;
	localparam int FP_NS_SLOW   = 200;
	localparam int FP_NS_FAST   = 150;
	localparam int FI_NS_SLOW   = 120;
	localparam int FI_NS_FAST   = 100;
	localparam int FC_NS_SLOW   = 330;
	localparam int FC_NS_FAST   = 270;

	typedef struct packed {
		logic                 write;
		logic [ADDR_BITS-1:0] addr;
		logic                 wdata;
	} mem_req_t;

	typedef struct packed {
		logic                ras_n;
		logic                cas_n;
		logic                we_n;
		logic                refresh_request_n;
		logic [ROW_BITS-1:0] mux_address_lines;
		logic                din;
	} dram_pins_t;

	localparam dram_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 1'b0};

	typedef enum {ST_INIT_WAIT, ST_IDLE, ST_ACCESS, ST_REFRESH} ctrl_state_t;
	typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_RAS_ONLY}
		cycle_kind_t;

	// least time: round up, never below one cycle
	function automatic int ns_to_cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int imax(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

endpackage

// ===== rtl/dram_ctrl.sv
// Purpose: host controller driving a 64k x 1 multiplexed-address dram
// Assumes: dout_i is synchronous to clk_sys_i; one outstanding access
// Notes:   random cycles only, refresh by the refresh request pin
// What this block does
// - refresh request at least 128 times per 2 ms
// - 200 us pause then 8 row-strobe cycles
// - 8 refresh request cycles before relying on counter
// - refresh request pin idle high when unused
// - read keeps write select high after strobes rise
// - random cycle starts spaced by cycle period
// - page mode precharge and cycle minimums; no page mode here, one column strobe per row cycle
// - refresh pin strobe timings only for counter tests
// - row-strobe-only cycle refreshes row, output idle
// - write select high reads, low writes
`timescale 1ns/1ps
module dram_ctrl
	import dram_ctrl_pkg::*;
#(
	parameter bit FAST_GRADE      = 1'b0,
	parameter int INIT_WAIT_CYC   = ns_to_cyc_min(INIT_PAUSE_US * 1000),
	parameter int REFRESH_GAP_CYC = REFRESH_SLOT_NS / CLK_PERIOD_NS
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_n_i,
	input  wire logic       req_valid_i,
	input  wire mem_req_t   req_i,
	input  wire logic       dout_i,
	output logic            req_ready_o,
	output logic            rsp_valid_o,
	output logic            rsp_rdata_o,
	output logic            init_done_o,
	output dram_pins_t      dram_o
);

	// pick the grade's figure and round it up to whole cycles
	function automatic int grade_cyc(input int fast_ns, input int slow_ns);
		return ns_to_cyc_min(FAST_GRADE ? fast_ns : slow_ns);
	endfunction

	localparam int RC_CYC   = grade_cyc(RC_NS_FAST, RC_NS_SLOW);
	localparam int RAC_CYC  = grade_cyc(RAC_NS_FAST, RAC_NS_SLOW);
	localparam int CAC_CYC  = grade_cyc(CAC_NS_FAST, CAC_NS_SLOW);
	localparam int RASW_CYC = grade_cyc(RASW_NS_FAST, RASW_NS_SLOW);
	localparam int CASW_CYC = grade_cyc(CASW_NS_FAST, CASW_NS_SLOW);
	localparam int RP_CYC   = grade_cyc(RP_NS_FAST, RP_NS_SLOW);
	localparam int RAH_CYC  = grade_cyc(RAH_NS_FAST, RAH_NS_SLOW);
	localparam int FP_CYC   = grade_cyc(FP_NS_FAST, FP_NS_SLOW);
	localparam int FI_CYC   = grade_cyc(FI_NS_FAST, FI_NS_SLOW);
	localparam int FC_CYC   = grade_cyc(FC_NS_FAST, FC_NS_SLOW);

	// edge numbers counted from the row strobe fall at edge 0
	localparam int C_COL    = RAH_CYC;
	localparam int C_CAS    = C_COL + 1;
	localparam int C_END    = imax(imax(C_CAS + CAC_CYC, RAC_CYC),
		imax(C_CAS + CASW_CYC, RASW_CYC));
	localparam int C_DONE   = imax(C_END + RP_CYC, RC_CYC) - 1;
	localparam int C_FDONE  = imax(FP_CYC + FI_CYC, FC_CYC) - 1;

	localparam logic [CNT_BITS-1:0] E_COL   = CNT_BITS'(C_COL - 1);
	localparam logic [CNT_BITS-1:0] E_CAS   = CNT_BITS'(C_CAS - 1);
	localparam logic [CNT_BITS-1:0] E_END   = CNT_BITS'(C_END - 1);
	localparam logic [CNT_BITS-1:0] E_DONE  = CNT_BITS'(C_DONE - 1);
	localparam logic [CNT_BITS-1:0] E_FP    = CNT_BITS'(FP_CYC - 1);
	localparam logic [CNT_BITS-1:0] E_FDONE = CNT_BITS'(C_FDONE - 1);
	localparam logic [TIMER_BITS-1:0] INIT_LAST = TIMER_BITS'(INIT_WAIT_CYC - 1);
	localparam logic [TIMER_BITS-1:0] REF_LAST  = TIMER_BITS'(REFRESH_GAP_CYC - 1);
	localparam logic [3:0] RAS_INIT_RST  = 4'(INIT_RAS_CYCLES);
	localparam logic [3:0] REFRESH_REQUEST_N_INIT_RST = 4'(INIT_REFRESH_REQUEST_N_CYCLES);

	ctrl_state_t            state_r;
	ctrl_state_t            state_nxt;
	cycle_kind_t            kind_r;
	cycle_kind_t            kind_nxt;
	mem_req_t               req_r;
	mem_req_t               req_nxt;
	dram_pins_t             dram_r;
	dram_pins_t             dram_nxt;
	logic [CNT_BITS-1:0]    cnt_r;
	logic [CNT_BITS-1:0]    cnt_nxt;
	logic [TIMER_BITS-1:0]  init_cnt_r;
	logic [TIMER_BITS-1:0]  init_cnt_nxt;
	logic [TIMER_BITS-1:0]  ref_cnt_r;
	logic [3:0]             ras_left_r;
	logic [3:0]             ras_left_nxt;
	logic [3:0]             refresh_request_n_left_r;
	logic [3:0]             refresh_request_n_left_nxt;
	logic                   ref_pend_r;
	logic                   ref_pend_nxt;
	logic                   take_ref;
	logic                   rsp_r;
	logic                   rsp_nxt;
	logic                   rdata_r;
	logic                   rdata_nxt;
	logic                   ready_r;
	logic                   ready_nxt;
	logic                   init_done_r;
	logic                   init_done_nxt;

	wire ref_tick     = (ref_cnt_r == REF_LAST);
	wire accept       = req_valid_i && ready_r;
	wire strobe_cycle = (kind_r != KIND_RAS_ONLY);

	// free-running slot timer; a late slot never pushes the next one back
	assign ref_pend_nxt = ref_tick || (ref_pend_r && !take_ref);
	assign init_done_nxt = (state_nxt != ST_INIT_WAIT) &&
		(ras_left_nxt == 4'h0) && (refresh_request_n_left_nxt == 4'h0);
	assign ready_nxt = (state_nxt == ST_IDLE) && init_done_nxt &&
		!ref_pend_nxt;

	always_comb begin
		state_nxt     = state_r;
		kind_nxt      = kind_r;
		req_nxt       = req_r;
		dram_nxt      = dram_r;
		cnt_nxt       = cnt_r + 8'h01;
		init_cnt_nxt  = init_cnt_r;
		ras_left_nxt  = ras_left_r;
		refresh_request_n_left_nxt = refresh_request_n_left_r;
		take_ref      = 1'b0;
		rsp_nxt       = 1'b0;
		rdata_nxt     = rdata_r;
		case (state_r)
			ST_INIT_WAIT: begin
				dram_nxt = PINS_IDLE;
				if (init_cnt_r == INIT_LAST) begin
					state_nxt = ST_IDLE;
				end else begin
					init_cnt_nxt = init_cnt_r + 16'h0001;
				end
			end
			ST_IDLE: begin
				cnt_nxt  = 8'h00;
				dram_nxt = PINS_IDLE;
				if (ras_left_r != 4'h0) begin
					state_nxt    = ST_ACCESS;
					kind_nxt     = KIND_RAS_ONLY;
					ras_left_nxt = ras_left_r - 4'h1;
					dram_nxt.ras_n = 1'b0;
					dram_nxt.mux_address_lines = {1'b0, 7'(ras_left_r)};
				end else if ((refresh_request_n_left_r != 4'h0) || ref_pend_r) begin
					state_nxt = ST_REFRESH;
					// row strobe already high, so this starts a refresh
					// plain refresh only, so counter-test set-ups do not apply
					dram_nxt.refresh_request_n = 1'b0;
					if (refresh_request_n_left_r != 4'h0) begin
						refresh_request_n_left_nxt = refresh_request_n_left_r - 4'h1;
					end else begin
						take_ref = 1'b1;
					end
				end else if (accept) begin
					state_nxt = ST_ACCESS;
					kind_nxt  = req_i.write ? KIND_WRITE : KIND_READ;
					req_nxt   = req_i;
					dram_nxt.ras_n = 1'b0;
					dram_nxt.mux_address_lines =
						req_i.addr[ADDR_BITS-1:COL_BITS];
				end
			end
			ST_ACCESS: begin
				if ((cnt_r == E_COL) && strobe_cycle) begin
					dram_nxt.mux_address_lines =
						req_r.addr[COL_BITS-1:0];
					// only early writes: avoids the undefined output case
					if (kind_r == KIND_WRITE) begin
						dram_nxt.we_n = 1'b0;
						dram_nxt.din  = req_r.wdata;
					end
				end
				// one column strobe per row cycle: no page mode precharge
				if ((cnt_r == E_CAS) && strobe_cycle) begin
					dram_nxt.cas_n = 1'b0;
				end
				if (cnt_r == E_END) begin
					dram_nxt = PINS_IDLE;
					if (kind_r == KIND_READ) begin
						rsp_nxt   = 1'b1;
						rdata_nxt = dout_i;
					end
				end
				if (cnt_r == E_DONE) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_REFRESH: begin
				if (cnt_r == E_FP) begin
					dram_nxt.refresh_request_n = 1'b1;
				end
				if (cnt_r == E_FDONE) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_INIT_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r     <= ST_INIT_WAIT;
			kind_r      <= KIND_READ;
			req_r       <= '0;
			dram_r      <= PINS_IDLE;
			cnt_r       <= 8'h00;
			init_cnt_r  <= 16'h0000;
			ras_left_r  <= RAS_INIT_RST;
			refresh_request_n_left_r <= REFRESH_REQUEST_N_INIT_RST;
		end else begin
			state_r     <= state_nxt;
			kind_r      <= kind_nxt;
			req_r       <= req_nxt;
			dram_r      <= dram_nxt;
			cnt_r       <= cnt_nxt;
			init_cnt_r  <= init_cnt_nxt;
			ras_left_r  <= ras_left_nxt;
			refresh_request_n_left_r <= refresh_request_n_left_nxt;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_cnt_r   <= 16'h0000;
			ref_pend_r  <= 1'b0;
			rsp_r       <= 1'b0;
			rdata_r     <= 1'b0;
			ready_r     <= 1'b0;
			init_done_r <= 1'b0;
		end else begin
			ref_cnt_r   <= ref_tick ? 16'h0000 : ref_cnt_r + 16'h0001;
			ref_pend_r  <= ref_pend_nxt;
			rsp_r       <= rsp_nxt;
			rdata_r     <= rdata_nxt;
			ready_r     <= ready_nxt;
			init_done_r <= init_done_nxt;
		end
	end

	assign req_ready_o = ready_r;
	assign rsp_valid_o = rsp_r;
	assign rsp_rdata_o = rdata_r;
	assign init_done_o = init_done_r;
	assign dram_o      = dram_r;

endmodule

// ===== bench/dram_ctrl_properties.sv
// Purpose: port timing checks for dram_ctrl
// Assumes: slower grade timing
// Notes:   bound to every instance
`timescale 1ns/1ps
module dram_ctrl_checker
	import dram_ctrl_pkg::*;
#(parameter int REFRESH_GAP_CYC = 312) (
	input wire logic       clk_sys_i,
	input wire logic       rst_n_i,
	input wire logic       req_valid_i,
	input wire mem_req_t   req_i,
	input wire logic       req_ready_o,
	input wire logic       rsp_valid_o,
	input wire logic       init_done_o,
	input wire dram_pins_t dram_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire         acc = req_valid_i && req_ready_o;
	logic [15:0] gap_r;
	// slack covers an access that delays a due refresh
	always_ff @(posedge clk_sys_i or negedge rst_n_i)
		if (!rst_n_i) gap_r <= '0;
		else gap_r <= (init_done_o && dram_o.refresh_request_n) ?
			gap_r + 16'h0001 : '0;
	a_init_no_ready: assert property (!init_done_o |-> !req_ready_o)
		else $error("ready during init");
	a_refresh_gap: assert property (gap_r <= 16'(REFRESH_GAP_CYC + 16))
		else $error("refresh overdue");
	a_refresh_pulse: assert property ($fell(dram_o.refresh_request_n) |->
		(dram_o.ras_n && !dram_o.refresh_request_n)[*4] ##1
		dram_o.refresh_request_n) else $error("refresh pulse wrong");
	a_row_byte: assert property (acc |=> !dram_o.ras_n &&
		dram_o.mux_address_lines == $past(req_i.addr[15:8]))
		else $error("row byte wrong");
	a_col_byte: assert property (acc |-> ##2
		dram_o.mux_address_lines == $past(req_i.addr[7:0], 2) ##1 !dram_o.cas_n)
		else $error("column byte wrong");
	a_early_write: assert property ($fell(dram_o.cas_n) |->
		!dram_o.ras_n && $stable(dram_o.we_n)) else $error("late write select");
	a_write_data: assert property (acc && req_i.write |-> ##2
		!dram_o.we_n && dram_o.din == $past(req_i.wdata, 2))
		else $error("write data wrong");
	a_read_hold: assert property (acc && !req_i.write |=> dram_o.we_n[*6])
		else $error("write select dropped in read");
	a_cycle_space: assert property ($fell(dram_o.ras_n) |=>
		(!$fell(dram_o.ras_n))[*6]) else $error("cycles too close");
	a_read_answer: assert property (acc |-> ##6
		rsp_valid_o == !$past(req_i.write, 6)) else $error("response timing");
	a_cas_precharge: assert property ($rose(dram_o.cas_n) |->
		dram_o.cas_n[*2]) else $error("column strobe precharge short");
	a_ras_only_idle: assert property (!init_done_o &&
		$fell(dram_o.ras_n) |-> dram_o.cas_n[*6])
		else $error("column strobe in row-only cycle");
endmodule
bind dram_ctrl dram_ctrl_checker
	#(.REFRESH_GAP_CYC(REFRESH_GAP_CYC)) chk_u (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
	.req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
	.init_done_o(init_done_o), .dram_o(dram_o));

// ===== bench/dram_cell_model.sv
// Purpose: behavioural 64k x 1 memory facing dram_ctrl
// Assumes: early write and plain read cycles
// Notes:   released output shows the inverse bit, never a stale one
`timescale 1ns/1ps
module dram_cell_model
	import dram_ctrl_pkg::*;
(
	input  wire dram_pins_t pins_i,
	output logic            dout_o
);
	logic        arr[0:65535];
	logic [15:0] adr_r;
	logic [6:0]  rcnt_r;
	logic        last_r = 1'b1;
	realtime     t_ras;
	int          wait_ns;
	initial dout_o = 1'b0;
	initial rcnt_r = 7'h00;
	always @(negedge pins_i.ras_n) begin
		adr_r[15:8] = pins_i.mux_address_lines;
		t_ras = $realtime;
	end
	always @(negedge pins_i.cas_n) begin
		adr_r[7:0] = pins_i.mux_address_lines;
		if (!pins_i.we_n)
			arr[adr_r] = pins_i.din;
		else begin
			// wrong bit until the slower access path is met
			dout_o = ~arr[adr_r];
			wait_ns = imax(CAC_NS_SLOW,
				RAC_NS_SLOW - int'($realtime - t_ras));
			#(wait_ns) last_r = arr[adr_r];
			dout_o = last_r;
		end
	end
	// late write select strobes data on its own edge
	always @(negedge pins_i.we_n)
		if (!pins_i.cas_n && !pins_i.ras_n) arr[adr_r] = pins_i.din;
	// no pull on the line, so a floating output must not look valid
	always @(posedge pins_i.cas_n)
		#20 dout_o = ~last_r;
	always @(posedge pins_i.refresh_request_n)
		if (pins_i.ras_n) rcnt_r = rcnt_r + 7'h01;
endmodule

// ===== bench/test_dram_ctrl.sv
// Purpose: self-checking bench for dram_ctrl with a memory model
// Assumes: short init pause and refresh gap
// Notes:   second pass resets mid-run and reads back old data
`timescale 1ns/1ps
module test_dram_ctrl
	import dram_ctrl_pkg::*;
();
	logic        clk_sys_i, rst_n_i, req_valid_i, dout_i;
	logic        req_ready_o, rsp_valid_o, rsp_rdata_o, init_done_o;
	mem_req_t    req_i;
	dram_pins_t  dram_o;
	int          fail_count, samples_checked, n;
	logic        exp_q[$];
	logic        sh[logic [15:0]];
	logic [15:0] a;
	logic [15:0] bnd[4] = '{16'h0000, 16'hFFFF, 16'h00FF, 16'hFF00};
	dram_ctrl #(.INIT_WAIT_CYC(20), .REFRESH_GAP_CYC(60)) dut_u (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .dout_i(dout_i), .req_ready_o(req_ready_o),
		.rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
		.init_done_o(init_done_o), .dram_o(dram_o));
	dram_cell_model model_u (.pins_i(dram_o), .dout_o(dout_i));
	task automatic chk(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic final_report();
		if (fail_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// the init and ready waits go through here, so a hang ends the run
	task automatic step(input int lim);
		@(posedge clk_sys_i);
		n++;
		if (n >= lim) begin
			fail_count++;
			final_report();
		end
	endtask
	// valid stays up after the take; the next call replaces the request
	// ready is looked at mid-cycle, where it has settled
	task automatic op(input logic w, input logic [15:0] ad, input logic d);
		logic seen;
		req_valid_i <= 1'b1;
		req_i       <= '{w, ad, d};
		n = 0;
		do begin
			@(negedge clk_sys_i);
			seen = (req_ready_o === 1'b1);
			step(200);
		end while (!seen);
		if (w) sh[ad] = d;
		else exp_q.push_back(sh[ad]);
	endtask
	always @(negedge clk_sys_i)
		if (rsp_valid_o === 1'b1)
			chk("read data", exp_q.size() ? exp_q.pop_front() : 1'bX,
				rsp_rdata_o);
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	initial begin
		{rst_n_i, req_valid_i, req_i} = '0;
		fail_count = 0;
		samples_checked = 0;
		void'($urandom(32'h4485));
		for (int p = 0; p < 2; p++) begin
			repeat (20) @(posedge clk_sys_i);
			chk("ready in reset", 1'b0, req_ready_o);
			rst_n_i <= 1'b1;
			n = 0;
			do
				step(2000);
			while (init_done_o !== 1'b1);
			chk("init length", 1'b1, n > 100);
			for (int i = 4 * (1 - p); i < 12; i++)
				op(i / 4 == 1, bnd[i % 4], i[0] ^ p[0]);
			repeat (30) begin
				a = 16'($urandom);
				op(1'b1, a, 1'($urandom));
				op(1'b0, a, 1'b0);
			end
			req_valid_i <= 1'b0;
			repeat (200) @(posedge clk_sys_i);
			chk("reads answered", 1'b1, exp_q.size() == 0);
			rst_n_i <= 1'b0;
		end
		final_report();
	end
endmodule
